// file: core/ird_defs.svh
// Functional notes
// RULE_01: Bits 17..8 hold enables of lines 49..40.
// RULE_02: Bits 6..0 hold enables of lines 38..32.
// RULE_03: Write one disables line; zero changes nothing. A set request in the same cycle keeps the line enabled instead.
// RULE_04: Read shows enable state, one means enabled.
// RULE_05: Bits 31..18 read zero; bit 7 zero; reset clears.
`ifndef IRD_DEFS_SVH
`define IRD_DEFS_SVH

// Byte address of the disable/status register
`define IRD_DISABLE_OFS 12'h000
// Default register bus address width
`define IRD_ADDR_W 12
// Number of enable bits kept, in register layout
`define IRD_EN_W 18
// Implemented enable positions: 17..8 and 6..0
`define IRD_IMPL_MASK 18'h3ff7f
// Enable state after reset
`define IRD_EN_RESET 18'h00000
// Field positions of the two line groups
`define IRD_HI_MSB 17
`define IRD_HI_LSB 8
`define IRD_LO_MSB 6
`define IRD_LO_LSB 0
// Reset value of the read data register
`define IRD_RDATA_RESET 32'h00000000

`endif

// file: core/ird_pkg.sv
package ird_pkg;
    // Enable vector in register bit layout, index = line - 32
    typedef logic [17:0] ird_en_t;
    // Bus response codes
    typedef enum logic [1:0] {
        IRD_RESP_OKAY = 2'b00,
        IRD_RESP_SLVERR = 2'b10
    } ird_resp_t;
endpackage

// file: core/ird_en_if.sv
`timescale 1ns/10ps
// Carries clear and set requests to the enable store and its state back
interface ird_en_if;
    import ird_pkg::*;
    logic clr_valid;   // One-cycle clear request
    ird_en_t clr_mask; // Ones select enables to drop
    ird_en_t set_mask; // Ones select enables to raise
    ird_en_t en_state; // Current enable state
    modport ctrl (output clr_valid, output clr_mask, output set_mask, input en_state);
    modport bank (input clr_valid, input clr_mask, input set_mask, output en_state);
endinterface

// file: core/ird_en_bank.sv
`timescale 1ns/10ps
`include "ird_defs.svh"
// Per-line enable store shared by the set and disable registers
module ird_en_bank
    import ird_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    ird_en_if.bank en
);
    ird_en_t en_q; // Enable flip-flops
    ird_en_t en_d; // Next enable state

    // Set wins over a clear that lands in the same cycle
    always_comb begin
        en_d = en_q;
        if (en.clr_valid) begin
            en_d = en_d & ~en.clr_mask; // see RULE_03
        end
        en_d = (en_d | en.set_mask) & `IRD_IMPL_MASK; // see RULE_05
    end

    // Enable register, cleared by reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= `IRD_EN_RESET; // see RULE_05
        end else begin
            en_q <= en_d;
        end
    end

    assign en.en_state = en_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A requested clear takes effect unless a set arrives with it
    property p_clear_drops;
        en.clr_valid |=> (en_q & $past(en.clr_mask) & ~$past(en.set_mask)) == '0;
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("enable survived a clear"); // see RULE_03

    // Without a clear request carrying ones in its mask, no enable drops
    property p_zero_keeps;
        (!en.clr_valid || en.clr_mask == '0) |=> (($past(en_q) & ~en_q) == '0);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("enable dropped without request"); // see RULE_03

    // Position of missing line 39 stays zero
    property p_gap_zero;
        !en_q[7];
    endproperty
    a_gap_zero: assert property (p_gap_zero) else $error("unimplemented enable set"); // see RULE_05
endmodule

// file: core/ird_disable_top.sv
`timescale 1ns/10ps
`include "ird_defs.svh"
// Write-one-to-disable register for interrupt lines 32..49 on an AXI4-Lite slave
module ird_disable_top
    import ird_pkg::*;
#(
    parameter int ADDR_W = `IRD_ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Set requests from the matching set-enable register, same clock
    input wire logic [17:0] irq_enable_set,
    // Enable per line, index = line - 32
    output logic [17:0] irq_enable
);
    // Address widths the decode can serve, refused at elaboration
    // Below 3 bits there is no word index; above 32 the bus is not AXI4-Lite
    if (ADDR_W < 3 || ADDR_W > 32) begin : g_addr_w_check
        $error("ADDR_W must lie in 3..32");
    end

    localparam logic [ADDR_W-1:0] REG_OFS = ADDR_W'(`IRD_DISABLE_OFS);

    ird_en_if en ();

    logic awready_q; // Write address ready
    logic wready_q; // Write data ready
    logic aw_got_q; // Write address captured
    logic w_got_q; // Write data captured
    logic aw_hit_q; // Captured write address hits the register
    logic [31:0] wdata_q; // Captured write data
    logic [3:0] wstrb_q; // Captured write strobes
    logic bvalid_q; // Write response valid
    ird_resp_t bresp_q; // Write response code
    logic arready_q; // Read address ready
    logic rvalid_q; // Read data valid
    logic [31:0] rdata_q; // Read data register
    ird_resp_t rresp_q; // Read response code
    ird_en_t irq_enable_q; // Registered copy of enables for the output
    logic wr_go; // Both halves of a write are held, no response pending
    logic aw_take; // Write address handshake
    logic w_take; // Write data handshake
    logic ar_take; // Read address handshake

    // Word decode shared by the read and write paths
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2] == REG_OFS[ADDR_W-1:2];
    endfunction

    // Expand byte strobes into a bit mask over the enable field
    function automatic ird_en_t strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return m[17:0];
    endfunction

    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take = s_axi_wvalid && wready_q;
    assign ar_take = s_axi_arvalid && arready_q;
    assign wr_go = aw_got_q && w_got_q && !bvalid_q;

    // Clear request to the store, only for a hit on the register
    always_comb begin
        en.clr_valid = wr_go && aw_hit_q;
        // Ones clear, zeros leave lines alone; reserved positions masked
        en.clr_mask = wdata_q[17:0] & strb_mask(wstrb_q) & `IRD_IMPL_MASK; // see RULE_03
        en.set_mask = irq_enable_set & `IRD_IMPL_MASK;
    end

    ird_en_bank u_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(en)
    );

    // Write address capture; ready returns after the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            aw_got_q <= 1'b0;
            aw_hit_q <= 1'b0;
        end else if (aw_take) begin
            // Hold the address until the write completes
            awready_q <= 1'b0;
            aw_got_q <= 1'b1;
            aw_hit_q <= addr_hit(s_axi_awaddr);
        end else if (bvalid_q && s_axi_bready) begin
            // Response taken, open for the next write
            awready_q <= 1'b1;
            aw_got_q <= 1'b0;
        end
    end

    // Write data capture, independent of the address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            w_got_q <= 1'b0;
            wdata_q <= `IRD_RDATA_RESET;
            wstrb_q <= 4'h0;
        end else if (w_take) begin
            // Hold the data until the write completes
            wready_q <= 1'b0;
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (bvalid_q && s_axi_bready) begin
            // Response taken, open for the next write
            wready_q <= 1'b1;
            w_got_q <= 1'b0;
        end
    end

    // Write response, raised in the cycle the clear is applied
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= IRD_RESP_OKAY;
        end else if (wr_go) begin
            // Unmapped word answers with a slave error and changes nothing
            bvalid_q <= 1'b1;
            bresp_q <= aw_hit_q ? IRD_RESP_OKAY : IRD_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel: one read at a time, data one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= `IRD_RDATA_RESET;
            rresp_q <= IRD_RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            if (addr_hit(s_axi_araddr)) begin
                // Current enables; upper bits and bit 7 read zero
                rdata_q <= {14'h0000, en.en_state & `IRD_IMPL_MASK}; // see RULE_01 RULE_02 RULE_04 RULE_05
                rresp_q <= IRD_RESP_OKAY;
            end else begin
                // Unmapped word reads zero with a slave error
                rdata_q <= `IRD_RDATA_RESET;
                rresp_q <= IRD_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Registered enable output, one cycle behind the store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_q <= `IRD_EN_RESET; // see RULE_05
        end else begin
            irq_enable_q <= en.en_state;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq_enable = irq_enable_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Upper group of read data mirrors enables of lines 49..40
    property p_hi_map;
        (ar_take && addr_hit(s_axi_araddr)) |=>
            rdata_q[`IRD_HI_MSB:`IRD_HI_LSB] == $past(en.en_state[17:8]);
    endproperty
    a_hi_map: assert property (p_hi_map) else $error("upper group read mismatch"); // see RULE_01

    // Lower group of read data mirrors enables of lines 38..32
    property p_lo_map;
        (ar_take && addr_hit(s_axi_araddr)) |=>
            rdata_q[`IRD_LO_MSB:`IRD_LO_LSB] == $past(en.en_state[6:0]);
    endproperty
    a_lo_map: assert property (p_lo_map) else $error("lower group read mismatch"); // see RULE_02

    // A hit write of ones disables those lines at the output two cycles on
    property p_wr_disables;
        (wr_go && aw_hit_q && irq_enable_set == '0) ##1 (irq_enable_set == '0) |=>
            (irq_enable & $past(en.clr_mask, 2)) == '0;
    endproperty
    a_wr_disables: assert property (p_wr_disables) else $error("written one left line on"); // see RULE_03

    // A read is answered in the next cycle, with the address side closed
    property p_read_answer;
        ar_take |=> (rvalid_q && !arready_q);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late"); // see RULE_04

    // A taken answer ends and the address side opens again
    property p_read_done;
        (rvalid_q && s_axi_rready) |=> (!rvalid_q && arready_q);
    endproperty
    a_read_done: assert property (p_read_done) else $error("read answer not closed"); // see RULE_04

    // Reserved positions of read data are always zero
    property p_rsvd_zero;
        rvalid_q |-> (rdata_q[31:18] == 14'h0000 && !rdata_q[7]);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read bit set"); // see RULE_05
endmodule

// file: dv/irq_disable_bank_upper_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the disable register, both line groups
module irq_disable_bank_upper_tb_top;
    import ird_pkg::*;
    logic aclk;
    logic aresetn;
    logic [11:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [17:0] en_set, en_out;
    logic [31:0] rng = 32'h35293c81; // Fixed seed
    logic [17:0] en_m; // Expected enable state
    logic [31:0] rd, d;
    logic [1:0] rs;
    logic [3:0] st;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;

    ird_disable_top ird_disable_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq_enable_set(en_set), .irq_enable(en_out));

    // Clock at 200 MHz
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Hang guard: runs out long after the tests should end
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            summarize();
        end
    end

    // Next pseudo-random word
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // Enable state after a disable write with byte strobes
    function automatic logic [17:0] after_wr(input logic [17:0] e, input logic [31:0] v,
                                             input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & v;
        return e & ~m[17:0];
    endfunction

    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One bus write: address and data offered together, each released when taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                             output logic [1:0] r);
        rng = xs(rng);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awprot <= rng[2:0];
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    // One bus read
    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        rng = xs(rng);
        araddr <= a;
        arprot <= rng[2:0];
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Pulse set requests for one cycle, then let the state settle
    task automatic set_lines(input logic [17:0] m);
        en_set <= m;
        @(posedge aclk);
        en_set <= 18'h00000;
        repeat (3) @(posedge aclk);
        en_m = en_m | (m & 18'h3ff7f);
    endtask

    // Read back and compare both the register and the enable outputs
    task automatic verify();
        repeat (2) @(posedge aclk);
        axi_read(12'h000, rd, rs);
        check({30'h0, rs}, {30'h0, IRD_RESP_OKAY});
        check(rd, {14'h0, en_m});
        check({14'h0, en_out}, {14'h0, en_m});
    endtask

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb, awprot, arprot} = '0;
        en_set = 18'h00000;
        en_m = 18'h00000;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        verify();
        $display("test reset done");
        set_lines(18'h3ffff);
        verify();
        $display("test set all done");
        for (int i = 0; i < 18; i++) begin
            set_lines(18'h3ffff);
            d = (32'h1 << i) & 32'hffffff7f;
            axi_write(12'h000, d, 4'hf, rs);
            check({30'h0, rs}, {30'h0, IRD_RESP_OKAY});
            en_m = after_wr(en_m, d, 4'hf);
            verify();
        end
        $display("test walking one done");
        for (int i = 0; i < 30; i++) begin
            rng = xs(rng);
            set_lines(rng[17:0]);
            rng = xs(rng);
            d = rng & 32'hffffff7f;
            st = (i < 4) ? 4'hf : d[31:28];
            axi_write(12'h000, d, st, rs);
            check({30'h0, rs}, {30'h0, IRD_RESP_OKAY});
            en_m = after_wr(en_m, d, st);
            verify();
        end
        $display("test random done");
        set_lines(18'h3ffff);
        axi_write(12'h004, 32'hffffffff, 4'hf, rs);
        check({30'h0, rs}, {30'h0, IRD_RESP_SLVERR});
        axi_read(12'hffc, rd, rs);
        check({30'h0, rs}, {30'h0, IRD_RESP_SLVERR});
        check(rd, 32'h00000000);
        axi_write(12'h000, 32'h00000000, 4'hf, rs);
        verify();
        $display("test unmapped done");
        // Reset in mid-run with every line enabled drops them all
        set_lines(18'h3ffff);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        en_m = 18'h00000;
        @(posedge aclk);
        verify();
        $display("test mid reset done");
        summarize();
    end
endmodule
